// ### cdpc_pkg.sv
package cdpc_pkg;

  // Core clock
  localparam int CLK_MHZ          = 100;

  // Device resumes normal operation at most this long after enable returns high
  localparam int T_RESUME_US      = 20;
  localparam int RESUME_CYCLES    = T_RESUME_US * CLK_MHZ;

  // Spacing between repeated COMRESET or COMWAKE bursts while waiting for an answer
  localparam int T_RETRY_US       = 10;
  localparam int RETRY_CYCLES     = T_RETRY_US * CLK_MHZ;

  // Timer width shared by all waits
  localparam int TIMER_W          = 16;

  // Presence pin level after power-up: low means a drive is assumed attached
  localparam logic PRESENT_N_RST  = 1'b0;

  // Device strap outputs from reset: device enabled, cable detect selected
  localparam logic DEV_ENABLE_RST = 1'b1;
  localparam logic SENSE_SEL_RST  = 1'b1;

  // Host link states
  typedef enum logic [2:0] {
    CDPC_STANDBY,
    CDPC_SETTLE,
    CDPC_OFF,
    CDPC_OOB,
    CDPC_LINK,
    CDPC_LOWPWR,
    CDPC_WAKE
  } cdpc_state_t;

  // Status reported to the user side
  typedef struct packed {
    logic drive_attached;
    logic phy_powered;
    logic link_active;
    logic low_power;
  } cdpc_status_t;

  // Orders to the phy layer of the host
  typedef struct packed {
    logic comreset;
    logic comwake;
    logic power_en;
    logic slumber;
  } cdpc_phy_ctl_t;

endpackage : cdpc_pkg

// ### cdpc_sync3.sv
`timescale 1ns/1ps

module cdpc_sync3 #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Asynchronous input
  input  wire logic async_in,
  // Filtered level
  output logic      sync_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Three-stage chain; only stage2 reads stage1
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a new level only once the last two stages agree, masking a late metastable flip
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_out <= INIT;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end

endmodule : cdpc_sync3

// ### cdpc_host_ctrl.sv
`timescale 1ns/1ps

module cdpc_host_ctrl
  import cdpc_pkg::*;
#(
  parameter int RESUME_WAIT = cdpc_pkg::RESUME_CYCLES,
  parameter int RETRY_WAIT  = cdpc_pkg::RETRY_CYCLES
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            reset,
  // User orders
  input  wire logic            host_enable,
  input  wire logic            detect_enable,
  input  wire logic            power_down_req,
  input  wire logic            wake_req,
  // User status
  output cdpc_pkg::cdpc_status_t status,
  // Host phy layer, same clock
  input  wire logic            phy_link_up,
  output cdpc_pkg::cdpc_phy_ctl_t phy_ctl,
  // Redriver pins
  input  wire logic            drive_present_n,
  output logic                 dev_enable,
  output logic                 presence_sense_select
);

  import cdpc_pkg::*;

  // Refuse timer settings the counter cannot hold, at elaboration
  if (RESUME_WAIT < 1 || RESUME_WAIT > (1 << TIMER_W)) begin : g_bad_resume
    $error("RESUME_WAIT out of range");
  end
  if (RETRY_WAIT < 1 || RETRY_WAIT > (1 << TIMER_W)) begin : g_bad_retry
    $error("RETRY_WAIT out of range");
  end

  localparam logic [TIMER_W-1:0] RESUME_LOAD = TIMER_W'(RESUME_WAIT - 1);
  localparam logic [TIMER_W-1:0] RETRY_LOAD  = TIMER_W'(RETRY_WAIT - 1);

  cdpc_state_t        state;
  cdpc_state_t        next_state;
  logic [TIMER_W-1:0] timer;
  logic               present_n_sync;
  logic               attached;
  logic               timer_done;

  // Presence pin crosses in from the device's analog detector; it only means
  // something when channel 1 faces this host and channel 2 faces the socket
  cdpc_sync3 #(
    .INIT     (PRESENT_N_RST)
  ) u_present_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (drive_present_n),
    .sync_out (present_n_sync)
  );

  // With detection deselected the pin carries no meaning, so assume a drive and train normally
  assign attached   = !detect_enable || !present_n_sync;
  assign timer_done = (timer == '0);

  // Device straps follow the user; reset leaves the device enabled with detect on
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dev_enable            <= DEV_ENABLE_RST;
      presence_sense_select <= SENSE_SEL_RST;
    end else begin
      dev_enable            <= host_enable;
      presence_sense_select <= detect_enable;
    end
  end

  // Link sequencing
  always_comb begin
    next_state = state;
    if (!host_enable) begin
      next_state = CDPC_STANDBY;
    end else begin
      case (state)
        CDPC_STANDBY: begin
          next_state = CDPC_SETTLE;
        end
        // Pin is stale until the device has resumed, so ignore it meanwhile
        CDPC_SETTLE: begin
          if (timer_done) begin
            next_state = attached ? CDPC_OOB : CDPC_OFF;
          end
        end
        CDPC_OFF: begin
          if (attached) begin
            next_state = CDPC_OOB;
          end
        end
        CDPC_OOB: begin
          if (!attached) begin
            next_state = CDPC_OFF;
          end else if (phy_link_up) begin
            next_state = CDPC_LINK;
          end
        end
        CDPC_LINK: begin
          if (!attached) begin
            next_state = CDPC_OFF;
          end else if (!phy_link_up) begin
            next_state = CDPC_OOB;
          end else if (power_down_req) begin
            next_state = CDPC_LOWPWR;
          end
        end
        // Removal is not seen here; the pin holds low until a wake
        CDPC_LOWPWR: begin
          if (wake_req) begin
            next_state = CDPC_WAKE;
          end
        end
        CDPC_WAKE: begin
          if (!attached) begin
            next_state = CDPC_OFF;
          end else if (phy_link_up) begin
            next_state = CDPC_LINK;
          end
        end
        default: begin
          next_state = CDPC_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= CDPC_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  // One timer serves the resume wait and the burst spacing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer <= '0;
    end else if (next_state != state) begin
      timer <= (next_state == CDPC_SETTLE) ? RESUME_LOAD : '0;
    end else if (timer_done && (state == CDPC_OOB || state == CDPC_WAKE)) begin
      timer <= RETRY_LOAD;
    end else if (!timer_done) begin
      timer <= timer - 1'b1;
    end
  end

  // Bursts go out on entry and then every retry period; none while shut down
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phy_ctl <= '0;
    end else begin
      phy_ctl.comreset <= (state == CDPC_OOB) && timer_done && (next_state == CDPC_OOB);
      phy_ctl.comwake  <= (state == CDPC_WAKE) && timer_done && (next_state == CDPC_WAKE);
      phy_ctl.power_en <= (next_state == CDPC_OOB) || (next_state == CDPC_LINK) ||
                          (next_state == CDPC_LOWPWR) || (next_state == CDPC_WAKE);
      phy_ctl.slumber  <= (next_state == CDPC_LOWPWR);
    end
  end

  // Status view, registered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status.drive_attached <= attached;
      status.phy_powered    <= (next_state == CDPC_OOB) || (next_state == CDPC_LINK) ||
                               (next_state == CDPC_LOWPWR) || (next_state == CDPC_WAKE);
      status.link_active    <= (next_state == CDPC_LINK);
      status.low_power      <= (next_state == CDPC_LOWPWR);
    end
  end

endmodule : cdpc_host_ctrl

// ### cdpc_checker.sv
`timescale 1ns/1ps

module cdpc_checker
  import cdpc_pkg::*;
#(
  parameter int RESUME_WAIT = cdpc_pkg::RESUME_CYCLES,
  parameter int RETRY_WAIT  = cdpc_pkg::RETRY_CYCLES
) (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               reset,
  // User side
  input wire logic               host_enable,
  input wire logic               detect_enable,
  input wire logic               power_down_req,
  input wire logic               wake_req,
  input cdpc_pkg::cdpc_status_t  status,
  // Phy and pins
  input wire logic               phy_link_up,
  input cdpc_pkg::cdpc_phy_ctl_t phy_ctl,
  input wire logic               dev_enable,
  input wire logic               presence_sense_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [15:0] gap;
  // Cycles since last COMRESET; saturates so long silences never wrap
  always_ff @(posedge sys_clk) begin
    if (reset) gap <= 16'hffff;
    else if (phy_ctl.comreset) gap <= 16'h0000;
    else if (gap != 16'hffff) gap <= gap + 16'h0001;
  end
  a_enable_drop: assert property (
    !host_enable |=> !dev_enable ##1 !phy_ctl.power_en) else $error("standby late");
  a_select_copy: assert property (
    !$past(reset) |-> presence_sense_select == $past(detect_enable)) else $error("select");
  a_oob_powered: assert property (
    !phy_ctl.power_en |-> !(phy_ctl.comreset || phy_ctl.comwake)) else $error("oob off");
  a_retry_gap: assert property (
    phy_ctl.comreset |-> gap >= RETRY_WAIT - 1) else $error("retry gap");
  a_link_drive: assert property (
    status.link_active |-> status.drive_attached) else $error("link no drive");
  a_absent_off: assert property (
    !status.drive_attached |-> !phy_ctl.power_en) else $error("absent powered");
  a_sleep_entry: assert property (
    power_down_req && status.link_active && phy_link_up && host_enable
    |=> status.low_power && phy_ctl.slumber) else $error("sleep");
  a_wake_start: assert property (
    wake_req && status.low_power && host_enable
    |=> !phy_ctl.slumber ##1 phy_ctl.comwake) else $error("wake");
  c_link: cover property ($rose(status.link_active));
  c_sleep: cover property ($rose(status.low_power));
  c_wake: cover property (phy_ctl.comwake);
endmodule : cdpc_checker

bind cdpc_host_ctrl cdpc_checker #(.RESUME_WAIT(RESUME_WAIT), .RETRY_WAIT(RETRY_WAIT)) chk_u (
  .sys_clk, .reset, .host_enable, .detect_enable, .power_down_req, .wake_req, .status,
  .phy_link_up, .phy_ctl, .dev_enable, .presence_sense_select);

// ### cdpc_dev_model.sv
`timescale 1ns/1ps

module cdpc_dev_model
  import cdpc_pkg::*;
(
  // Clock and power-up
  input wire logic               sys_clk,
  input wire logic               reset,
  // From the controller
  input wire logic               dev_enable,
  input wire logic               presence_sense_select,
  input cdpc_pkg::cdpc_phy_ctl_t phy_ctl,
  // Drive behind the socket
  input wire logic               drive_in,
  input wire logic               cominit,
  // To the controller
  output logic                   drive_present_n,
  output logic                   link_up
);
  // Socket looked at only on host bursts, so a removal in slumber stays hidden
  always_ff @(posedge sys_clk) begin
    if (reset) drive_present_n <= 1'b0;
    else if (dev_enable && presence_sense_select) begin
      if ((phy_ctl.comreset || phy_ctl.comwake) && !drive_in)
        drive_present_n <= 1'b1;
      else if (drive_present_n && cominit) drive_present_n <= 1'b0;
    end
  end
  // Link trains on a burst with a drive fitted; standby, slumber idle or a pulled drive
  // drops it. Squelch and low-power exit are far below one clock, so a burst passes at once
  always_ff @(posedge sys_clk) begin
    if (reset || !dev_enable || !phy_ctl.power_en || phy_ctl.slumber || !drive_in)
      link_up <= 1'b0;
    else if ((phy_ctl.comreset || phy_ctl.comwake) && drive_in)
      link_up <= 1'b1;
  end
endmodule : cdpc_dev_model

// ### tb_cdpc_host_ctrl.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end

module tb_cdpc_host_ctrl;
  import cdpc_pkg::*;
  logic          sys_clk = 1'b0, reset = 1'b1, host_enable = 1'b1, detect_enable = 1'b1;
  logic          power_down_req = 1'b0, wake_req = 1'b0, drive_in = 1'b1, cominit = 1'b0;
  logic          phy_link_up, drive_present_n, dev_enable, presence_sense_select;
  cdpc_status_t  status;
  cdpc_phy_ctl_t phy_ctl;
  int            err_total = 0, checks = 0;
  // Rows: drive fitted, detect select, settled status; last row leaves the link up
  logic [5:0]    rows [4] = '{6'h10, 6'h2e, 6'h0c, 6'h3e};

  // Clock
  always #5 sys_clk = ~sys_clk;

  cdpc_host_ctrl #(.RESUME_WAIT(5), .RETRY_WAIT(4)) dut_u (.sys_clk, .reset, .host_enable,
    .detect_enable, .power_down_req, .wake_req, .status, .phy_link_up, .phy_ctl,
    .drive_present_n, .dev_enable, .presence_sense_select);
  cdpc_dev_model dev_u (.sys_clk, .reset, .dev_enable, .presence_sense_select, .phy_ctl,
    .drive_in, .cominit, .drive_present_n, .link_up(phy_link_up));

  task automatic final_report();
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // Bounded wait on masked status; a run-out is a mismatch and ends the run
  task automatic wait_st(input logic [3:0] m, input logic [3:0] v);
    int i;
    checks++;
    for (i = 0; i < 300 && (status & m) !== v; i++) @(negedge sys_clk);
    if (i == 300) begin
      err_total++;
      $display("ERROR status exp %h got %h", v, status & m);
      final_report();
    end
  endtask : wait_st

  task automatic pulse(ref logic s);
    @(negedge sys_clk) s = 1'b1;
    @(negedge sys_clk) s = 1'b0;
  endtask : pulse

  // Rows from power-up, then slumber removal, hot plug and standby
  initial begin
    foreach (rows[k]) begin
      @(negedge sys_clk) reset = 1'b1;
      {drive_in, detect_enable} = rows[k][5:4];
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      // Let the resume wait and first bursts pass, so reset-time zeros cannot match
      repeat (30) @(negedge sys_clk);
      wait_st(4'hf, rows[k][3:0]);
      `CHK("select", rows[k][4], presence_sense_select)
    end
    pulse(power_down_req);
    wait_st(4'h1, 4'h1);
    `CHK("slumber", 1'b1, phy_ctl.slumber)
    drive_in = 1'b0;
    repeat (20) @(negedge sys_clk);
    `CHK("presence", 1'b0, drive_present_n)
    pulse(wake_req);
    wait_st(4'h8, 4'h0);
    `CHK("power_en", 1'b0, phy_ctl.power_en)
    drive_in = 1'b1;
    pulse(cominit);
    wait_st(4'hf, 4'he);
    // Sleep and wake with the drive still fitted must come back to a trained link
    pulse(power_down_req);
    wait_st(4'h1, 4'h1);
    pulse(wake_req);
    wait_st(4'hf, 4'he);
    host_enable = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("dev_enable", 1'b0, dev_enable)
    `CHK("power_off", 1'b0, phy_ctl.power_en)
    host_enable = 1'b1;
    wait_st(4'hf, 4'he);
    // Pull the drive while linked: the burst after link loss finds the socket empty
    drive_in = 1'b0;
    wait_st(4'hf, 4'h0);
    `CHK("power_en", 1'b0, phy_ctl.power_en)
    final_report();
  end
endmodule : tb_cdpc_host_ctrl
